// ==== hdl/odurc_pkg.sv ====
/*
 * odurc_pkg: constants, field layout and state type for the octal dac
 * update and clear control block.
 * assumes: shared by the control module and the testbench; no clock or reset here.
 */
package odurc_pkg;

    // frame layout
    localparam int WORD_W = 24;
    localparam logic [4:0] WORD_CNT = 5'h18;
    localparam int CMD_MSB = 23;
    localparam int CMD_LSB = 20;
    localparam int ADDR_MSB = 19;
    localparam int ADDR_LSB = 16;
    localparam int DATA_MSB = 15;
    localparam int DATA_LSB = 0;

    // command codes
    localparam logic [3:0] CMD_WRITE_INPUT = 4'h1;
    localparam logic [3:0] CMD_COPY_TO_DAC = 4'h2;
    localparam logic [3:0] CMD_WRITE_UPDATE = 4'h3;
    localparam logic [3:0] CMD_LOAD_MASK = 4'h5;
    localparam logic [3:0] CMD_SOFT_RESET = 4'h6;
    localparam logic [3:0] CMD_REF_GAIN = 4'h7;

    // software reset key
    localparam logic [3:0] SOFT_RESET_ADDR = 4'h0;
    localparam logic [15:0] SOFT_RESET_KEY = 16'h1234;

    // reference and gain setup word, mask reset value
    localparam int GAIN_BIT = 2;
    localparam int REF_OFF_BIT = 0;
    localparam logic GAIN_RESET = 1'h0;
    localparam logic REF_OFF_RESET = 1'h0;
    localparam logic [7:0] MASK_RESET = 8'h00;

    // pin synchroniser lanes
    localparam int PIN_N = 6;
    localparam int PIN_SCLK = 0;
    localparam int PIN_SDI = 1;
    localparam int PIN_FRAME = 2;
    localparam int PIN_LOAD = 3;
    localparam int PIN_CLEAR = 4;
    localparam int PIN_CLRSEL = 5;
    localparam logic [PIN_N-1:0] PIN_RESET = 6'h3C;

    // timing
    localparam int CLK_MHZ = 100;
    localparam int POR_TIME_NS = 2000;
    localparam int POR_CNT_W = 16;

    typedef enum logic [1:0] {
        ODURC_POR_COUNT,
        ODURC_POR_HOLD,
        ODURC_RUN
    } odurc_state_e;

endpackage

// ==== hdl/odurc_ctrl.sv ====
/*
 * odurc_ctrl: update, clear and setup control of an eight channel serially
 * programmed dac. receives 24-bit frames, keeps input and dac registers,
 * the per-channel load mask and the reference and gain setup word.
 * assumes: all pins arrive asynchronous to clk and are sampled here;
 * the serial clock is much slower than clk (80 ns against 10 ns).
 */
// Functional notes
// - write-input with load strobe low also updates that dac register at frame end
// - strobe high during writes, later pulsed low, updates dacs at the falling edge
// - command 0101 loads the 8-bit mask from data bits 7..0, address ignored
// - mask bits reset to zero so all channels follow the strobe
// - masked channel treats the strobe as permanently high
// - copy command leaves input registers alone, whatever the strobe level
// - copy command data bit n selects channel n for input-to-dac transfer
// - write-and-update writes input and dac registers, whatever the strobe level
// - write-input with strobe high changes only the input register
// - every strobe falling edge copies input to dac on unmasked channels
// - strobe tied low since start-up makes the mask irrelevant
// - clear pin low forces outputs to zero scale or midscale per select pin
// - cleared value holds after release; no updates while clear is low
// - strobe and clear pins ignored during power-on reset; here clear low holds start-up until released
// - start-up code is zero scale or midscale per select pin until a write
// - without the select pin, start-up code is zero
// - command 0110 resets only with address 0 and data 1234 hex
// - command 0111 stores gain in bit 2 and reference disable in bit 0
// - gain bit zero means gain one (default), one means gain two
// - reference bit zero keeps reference on (default), one turns it off
// - each command is a 24-bit word, acted upon at frame select rising
`timescale 1ns/1ps
module odurc_ctrl #(
    parameter int NUM_CH = 8,
    parameter int DATA_BITS = 16,
    parameter bit HAS_CLEAR_SELECT = 1'b1,
    parameter int POR_TIME = odurc_pkg::POR_TIME_NS
) (
    // clock, reset, enable
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // serial link
    input wire logic sclk,
    input wire logic sdi,
    input wire logic frame_select_n,
    // control pins
    input wire logic load_strobe_n,
    input wire logic clear_n,
    input wire logic clear_level_select,
    // channel codes, channel n at bits n*DATA_BITS upward
    output logic [NUM_CH*DATA_BITS-1:0] input_code,
    output logic [NUM_CH*DATA_BITS-1:0] dac_code,
    // setup and status
    output logic [NUM_CH-1:0] channel_update_mask,
    output logic gain_two,
    output logic ref_off,
    output logic por_busy
);
    import odurc_pkg::*;

    localparam int POR_CYCLES = (POR_TIME * CLK_MHZ + 999) / 1000;
    localparam logic [POR_CNT_W-1:0] POR_LAST = POR_CNT_W'(POR_CYCLES - 1);

    // clear code from the select level
    function automatic logic [DATA_BITS-1:0] clear_code(input logic sel);
        logic [DATA_BITS-1:0] code;
        code = '0;
        if (HAS_CLEAR_SELECT && sel) begin
            code[DATA_BITS-1] = 1'b1;
        end
        return code;
    endfunction

    // address hits channel index
    function automatic logic ch_hit(input logic [3:0] addr, input int idx);
        return addr == 4'(idx);
    endfunction

    // pin synchronisers
    logic [PIN_N-1:0] pin_s1;
    logic [PIN_N-1:0] pin_s2;
    logic [PIN_N-1:0] pin_s3;
    logic [PIN_N-1:0] pin_lvl;
    logic [PIN_N-1:0] pin_agree;
    logic [PIN_N-1:0] pin_rise;
    logic [PIN_N-1:0] pin_fall;

    assign pin_agree = ~(pin_s2 ^ pin_s3);
    assign pin_rise = pin_agree & pin_s3 & ~pin_lvl;
    assign pin_fall = pin_agree & ~pin_s3 & pin_lvl;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pin_s1 <= PIN_RESET;
            pin_s2 <= PIN_RESET;
            pin_s3 <= PIN_RESET;
            pin_lvl <= PIN_RESET;
        end else if (ce) begin
            pin_s1 <= {clear_level_select, clear_n, load_strobe_n, frame_select_n, sdi, sclk};
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
            pin_lvl <= (pin_agree & pin_s3) | (~pin_agree & pin_lvl);
        end
    end

    // frame shifter
    logic [WORD_W-1:0] shift_word;
    logic [4:0] bit_cnt;
    logic frame_done;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            shift_word <= '0;
            bit_cnt <= '0;
        end else if (ce) begin
            if (pin_fall[PIN_FRAME]) begin
                bit_cnt <= '0;
            end else if (pin_rise[PIN_SCLK] && !pin_lvl[PIN_FRAME]) begin
                shift_word <= {shift_word[WORD_W-2:0], pin_s3[PIN_SDI]};
                if (bit_cnt != 5'h1F) begin
                    bit_cnt <= bit_cnt + 5'h01;
                end
            end
        end
    end

    // the word is taken once all 24 bits are in when frame select rises
    assign frame_done = pin_rise[PIN_FRAME] && (bit_cnt >= WORD_CNT);

    // decoded fields
    logic [3:0] f_cmd;
    logic [3:0] f_addr;
    logic [15:0] f_data;
    logic addr_ok;

    assign f_cmd = shift_word[CMD_MSB:CMD_LSB];
    assign f_addr = shift_word[ADDR_MSB:ADDR_LSB];
    assign f_data = shift_word[DATA_MSB:DATA_LSB];
    assign addr_ok = f_addr < 4'(NUM_CH);

    // power-on sequence
    odurc_state_e state;
    logic [POR_CNT_W-1:0] por_cnt;
    logic run;

    assign run = state == ODURC_RUN;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state <= ODURC_POR_COUNT;
            por_cnt <= '0;
            por_busy <= 1'b1;
        end else if (ce) begin
            case (state)
                ODURC_POR_COUNT: begin
                    por_cnt <= por_cnt + 1'b1;
                    if (por_cnt >= POR_LAST) begin
                        state <= ODURC_POR_HOLD;
                    end
                end
                ODURC_POR_HOLD: begin
                    // start-up completes only once clear is released
                    if (pin_lvl[PIN_CLEAR]) begin
                        state <= ODURC_RUN;
                        por_busy <= 1'b0;
                    end
                end
                ODURC_RUN: begin
                    por_busy <= 1'b0;
                end
                default: begin
                    state <= ODURC_POR_COUNT;
                    por_cnt <= '0;
                    por_busy <= 1'b1;
                end
            endcase
        end
    end

    // command qualifiers
    logic soft_reset;
    logic clearing;
    logic strobe_low;
    logic strobe_fall;
    logic strobe_tied_low;
    logic [DATA_BITS-1:0] clr_val;

    assign soft_reset = run && frame_done && f_cmd == CMD_SOFT_RESET
        && f_addr == SOFT_RESET_ADDR && f_data == SOFT_RESET_KEY;
    assign clearing = run && !pin_lvl[PIN_CLEAR];
    assign strobe_low = run && !pin_lvl[PIN_LOAD];
    assign strobe_fall = run && pin_fall[PIN_LOAD];
    assign clr_val = clear_code(pin_lvl[PIN_CLRSEL]);

    // strobe never seen high since start-up counts as tied low
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            strobe_tied_low <= 1'b1;
        end else if (ce) begin
            if (!run) begin
                strobe_tied_low <= 1'b1;
            end else if (pin_lvl[PIN_LOAD]) begin
                strobe_tied_low <= 1'b0;
            end
        end
    end

    // mask and setup registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            channel_update_mask <= MASK_RESET;
            gain_two <= GAIN_RESET;
            ref_off <= REF_OFF_RESET;
        end else if (ce) begin
            if (!run || soft_reset) begin
                channel_update_mask <= MASK_RESET;
                gain_two <= GAIN_RESET;
                ref_off <= REF_OFF_RESET;
            end else if (frame_done && f_cmd == CMD_LOAD_MASK) begin
                channel_update_mask <= f_data[NUM_CH-1:0];
            end else if (frame_done && f_cmd == CMD_REF_GAIN) begin
                // bit 1 is reserved and never stored
                gain_two <= f_data[GAIN_BIT];
                ref_off <= f_data[REF_OFF_BIT];
            end
        end
    end

    // channel registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            input_code <= '0;
            dac_code <= '0;
        end else if (ce) begin
            for (int ch = 0; ch < NUM_CH; ch++) begin
                logic hit;
                logic strobe_eff;
                logic wr_in;
                logic wr_dac;
                logic copy;
                hit = frame_done && addr_ok && ch_hit(f_addr, ch);
                // masked channel sees the strobe as high unless tied low
                strobe_eff = strobe_low && (!channel_update_mask[ch] || strobe_tied_low);
                wr_in = hit && (f_cmd == CMD_WRITE_INPUT || f_cmd == CMD_WRITE_UPDATE);
                wr_dac = hit && (f_cmd == CMD_WRITE_UPDATE
                    || (f_cmd == CMD_WRITE_INPUT && strobe_eff));
                copy = (frame_done && f_cmd == CMD_COPY_TO_DAC && f_data[ch])
                    || (strobe_fall && !channel_update_mask[ch]);
                if (!run || clearing || soft_reset) begin
                    // start-up, clear and software reset all hold the clear code
                    input_code[ch*DATA_BITS +: DATA_BITS] <= clr_val;
                    dac_code[ch*DATA_BITS +: DATA_BITS] <= clr_val;
                end else begin
                    if (wr_in) begin
                        input_code[ch*DATA_BITS +: DATA_BITS] <= f_data[DATA_BITS-1:0];
                    end
                    if (wr_dac) begin
                        dac_code[ch*DATA_BITS +: DATA_BITS] <= f_data[DATA_BITS-1:0];
                    end else if (copy) begin
                        dac_code[ch*DATA_BITS +: DATA_BITS] <= input_code[ch*DATA_BITS +: DATA_BITS];
                    end
                end
            end
        end
    end

endmodule

// ==== verification/odurc_host.sv ====
/* odurc_host: host serial master model, 24-bit frames, 80 ns sclk.
   assumes: clk 100 MHz; sclk stands low between frames. */
`timescale 1ns/1ps
module odurc_host (
    // clock
    input wire logic clk,
    // serial link
    output logic sclk = 1'b0,
    output logic sdi = 1'b0,
    output logic frame_select_n = 1'b1
);
    task automatic send(input logic [23:0] w);
        @(posedge clk) frame_select_n <= 1'b0;
        for (int i = 23; i >= 0; i--) begin
            sdi <= w[i];
            repeat (4) @(posedge clk);
            sclk <= 1'b1;
            repeat (4) @(posedge clk);
            sclk <= 1'b0;
        end
        repeat (4) @(posedge clk);
        frame_select_n <= 1'b1;
        sdi <= ~w[0];
        repeat (4) @(posedge clk);
    endtask
endmodule

// ==== verification/odurc_props.sv ====
/* odurc_props: port assertions of the update and clear control.
   assumes: bound to odurc_ctrl; ce held high. */
`timescale 1ns/1ps
module odurc_props #(
    parameter int NUM_CH = 8,
    parameter int DATA_BITS = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // pins
    input wire logic frame_select_n,
    input wire logic clear_n,
    input wire logic clear_level_select,
    // outputs
    input wire logic [NUM_CH*DATA_BITS-1:0] dac_code,
    input wire logic [NUM_CH-1:0] channel_update_mask,
    input wire logic gain_two,
    input wire logic ref_off,
    input wire logic por_busy
);
    logic [NUM_CH*DATA_BITS-1:0] clr_code;
    assign clr_code = {NUM_CH{clear_level_select, {(DATA_BITS-1){1'b0}}}};
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    reset_val_a: assert property ($rose(rst_n) |-> !channel_update_mask && !gain_two && !ref_off)
        else $error("setup not cleared");
    por_setup_a: assert property (por_busy |-> !gain_two && !ref_off)
        else $error("setup moved in start-up");
    por_code_a: assert property ((por_busy && $stable(clear_level_select)) [*6] |-> dac_code == clr_code)
        else $error("start-up code wrong");
    clear_code_a: assert property ((!clear_n && $stable(clear_level_select)) [*6] |-> dac_code == clr_code)
        else $error("clear code wrong");
    clear_hold_a: assert property (!clear_n [*8] |-> $stable(channel_update_mask))
        else $error("mask moved while clearing");
    mask_frame_a: assert property ($past(rst_n) && $changed(channel_update_mask) |->
        $past(frame_select_n, 3) && !$past(frame_select_n, 6)) else $error("mask moved without frame");
    setup_frame_a: assert property ($past(rst_n) && $changed({gain_two, ref_off}) |->
        $past(frame_select_n, 3) && !$past(frame_select_n, 6)) else $error("setup moved without frame");
    por_clear_a: assert property ($fell(por_busy) |-> $past(clear_n, 3) && clear_n)
        else $error("start-up ended under clear");
endmodule
bind odurc_ctrl odurc_props #(.NUM_CH(NUM_CH), .DATA_BITS(DATA_BITS)) odurc_props_inst (.clk(clk), .rst_n(rst_n),
    .frame_select_n(frame_select_n), .clear_n(clear_n), .clear_level_select(clear_level_select),
    .dac_code(dac_code), .channel_update_mask(channel_update_mask), .gain_two(gain_two), .ref_off(ref_off),
    .por_busy(por_busy));

// ==== verification/tb.sv ====
/* tb: self-checking bench of odurc_ctrl with the host model.
   assumes: start-up time shortened to 100 ns; ce tied high. */
`timescale 1ns/1ps
module tb;
    import odurc_pkg::*;
    logic clk, rst_n, load_strobe_n, clear_n, clear_level_select, sclk, sdi, frame_select_n;
    logic [127:0] input_code, dac_code;
    logic [7:0] channel_update_mask;
    logic gain_two, ref_off, por_busy;
    int errors, n_tests;
    odurc_host odurc_host_inst (.clk(clk), .sclk(sclk), .sdi(sdi), .frame_select_n(frame_select_n));
    odurc_ctrl #(.POR_TIME(100)) odurc_ctrl_inst (.clk(clk), .rst_n(rst_n), .ce(1'b1), .sclk(sclk), .sdi(sdi),
        .frame_select_n(frame_select_n), .load_strobe_n(load_strobe_n), .clear_n(clear_n),
        .clear_level_select(clear_level_select), .input_code(input_code), .dac_code(dac_code),
        .channel_update_mask(channel_update_mask), .gain_two(gain_two), .ref_off(ref_off), .por_busy(por_busy));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic test_done();
        $display("errors %0d checks %0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %s exp %h got %h", what, exp, got);
        end
    endtask
    function automatic logic [15:0] ch(input logic [127:0] v, input int n);
        return v[n*16+:16];
    endfunction
    task automatic frame(input logic [23:0] w);
        odurc_host_inst.send(w);
        repeat (6) @(posedge clk);
    endtask
    task automatic pulse();
        @(posedge clk) load_strobe_n <= 1'b0;
        repeat (8) @(posedge clk);
        load_strobe_n <= 1'b1;
        repeat (8) @(posedge clk);
    endtask
    task automatic t_power_up();
        int k;
        repeat (40) @(posedge clk);
        check("busy", 16'h0001, {15'h0, por_busy});
        check("por dac5", 16'h8000, ch(dac_code, 5));
        load_strobe_n <= 1'b1;
        repeat (8) @(posedge clk);
        clear_n <= 1'b1;
        for (k = 0; k < 100 && por_busy !== 1'b0; k++) @(posedge clk);
        if (k == 100) begin
            errors++;
            test_done();
        end
        check("mask", 16'h0000, {8'h00, channel_update_mask});
        check("por dac0", 16'h8000, ch(dac_code, 0));
    endtask
    task automatic t_deferred();
        frame({CMD_WRITE_INPUT, 4'h2, 16'h1111});
        check("in2", 16'h1111, ch(input_code, 2));
        check("dac2 held", 16'h8000, ch(dac_code, 2));
        pulse();
        check("dac2 pulsed", 16'h1111, ch(dac_code, 2));
        @(posedge clk) load_strobe_n <= 1'b0;
        frame({CMD_WRITE_INPUT, 4'h3, 16'h2222});
        check("dac3 live", 16'h2222, ch(dac_code, 3));
        load_strobe_n <= 1'b1;
        repeat (8) @(posedge clk);
    endtask
    task automatic t_mask();
        frame({CMD_LOAD_MASK, 4'hF, 16'hFF04});
        check("mask", 16'h0004, {8'h00, channel_update_mask});
        frame({CMD_WRITE_INPUT, 4'h2, 16'h3333});
        frame({CMD_WRITE_INPUT, 4'h0, 16'h4444});
        pulse();
        check("dac0", 16'h4444, ch(dac_code, 0));
        check("dac2 masked", 16'h1111, ch(dac_code, 2));
        frame({CMD_COPY_TO_DAC, 4'h0, 16'h0004});
        check("dac2 copy", 16'h3333, ch(dac_code, 2));
        check("in2 kept", 16'h3333, ch(input_code, 2));
        frame({CMD_WRITE_UPDATE, 4'h9, 16'h9999});
        check("dac1 bad addr", 16'h8000, ch(dac_code, 1));
        frame({CMD_WRITE_UPDATE, 4'h1, 16'h5555});
        check("dac1", 16'h5555, ch(dac_code, 1));
    endtask
    task automatic t_setup();
        frame({CMD_REF_GAIN, 20'hFFFFD});
        check("gain ref", 16'h0003, {14'h0, gain_two, ref_off});
        frame({CMD_SOFT_RESET, 4'h0, 16'h1235});
        frame({CMD_SOFT_RESET, 4'h1, SOFT_RESET_KEY});
        check("bad key", 16'h0004, {8'h00, channel_update_mask});
        frame({CMD_SOFT_RESET, SOFT_RESET_ADDR, SOFT_RESET_KEY});
        check("sw mask", 16'h0000, {8'h00, channel_update_mask});
        check("sw gain ref", 16'h0000, {14'h0, gain_two, ref_off});
        check("sw dac1", 16'h8000, ch(dac_code, 1));
    endtask
    task automatic t_clear();
        clear_level_select <= 1'b0;
        frame({CMD_WRITE_UPDATE, 4'h4, 16'h6666});
        clear_n <= 1'b0;
        repeat (10) @(posedge clk);
        check("clear", 16'h0000, ch(dac_code, 4));
        frame({CMD_WRITE_UPDATE, 4'h4, 16'h7777});
        check("blocked", 16'h0000, ch(dac_code, 4));
        clear_n <= 1'b1;
        repeat (10) @(posedge clk);
        check("held", 16'h0000, ch(dac_code, 4));
    endtask
    task automatic t_tied_low();
        int k;
        rst_n <= 1'b0;
        load_strobe_n <= 1'b0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        for (k = 0; k < 100 && por_busy !== 1'b0; k++) @(posedge clk);
        if (k == 100) begin
            errors++;
            test_done();
        end
        frame({CMD_LOAD_MASK, 4'h0, 16'h0001});
        check("tied mask", 16'h0001, {8'h00, channel_update_mask});
        frame({CMD_WRITE_INPUT, 4'h0, 16'hABCD});
        check("tied dac0", 16'hABCD, ch(dac_code, 0));
    endtask
    initial begin
        errors = 0;
        n_tests = 0;
        rst_n = 1'b0;
        load_strobe_n = 1'b0;
        clear_n = 1'b0;
        clear_level_select = 1'b1;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        t_power_up();
        t_deferred();
        t_mask();
        t_setup();
        t_clear();
        t_tied_low();
        test_done();
    end
endmodule
